// File: core/deglitch.sv
// one-bit deglitch filter: output follows input after it is stable
module deglitch
	import skip_ctrl_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic raw_i,
	output logic      filt_o
);
	logic [DEGL_W-1:0] cnt_r;
	logic              samp_r;

	// sample register so comparisons never see the raw pin directly
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			samp_r <= 1'b0;
		end else begin
			samp_r <= raw_i;
		end
	end

	// count cycles the sample differs from the output; any agreement restarts the count
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r  <= '0;
			filt_o <= 1'b0;
		end else if (samp_r == filt_o) begin
			cnt_r <= '0;
		end else if (cnt_r == DEGL_COUNT) begin
			cnt_r  <= '0;
			filt_o <= samp_r;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end
endmodule

// File: core/skip_ctrl.sv
// pulse skipping interpolator and input control for four power channels, plus channel six duty
module skip_ctrl
	import skip_ctrl_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// classic wishbone slave
	input  wire logic              cyc_i,
	input  wire logic              stb_i,
	input  wire logic              we_i,
	input  wire logic [7:0]        adr_i,
	input  wire logic [3:0]        sel_i,
	input  wire logic [31:0]       dat_i,
	output logic [31:0]            dat_o,
	output logic                   ack_o,
	// pins and pwm timing
	input  wire logic [N_PWR-1:0]  control_inputs_i,
	input  wire logic [N_PWR-1:0]  filtered_input_alt_i,
	input  wire logic              period_start_i,
	input  wire logic              clk_fail_i,
	output logic [N_PWR-1:0]       wake_o,
	output logic [N_PWR-1:0]       channel_command_o,
	output logic                   channel_six_command_o,
	output logic [N_PWR-1:0]       window_start_o,
	output logic [N_PWR-1:0]       window_ctrl_o,
	output logic [N_PWR*DUTY_W-1:0] duty_value_o,
	output logic [DUTY_W-1:0]      ext_duty_value_o,
	output logic                   pwm_enable_o
);
	// ************************************
	// register file
	// ************************************
	logic [31:0]              out_ctrl_r;
	logic [31:0]              in_en_r;
	logic [31:0]              mode_r;
	logic [31:0]              presc_r;
	logic [DUTY_W-1:0]        duty_r [N_PWR+1];
	logic [FRAME_W-1:0]       frame_r;
	logic [N_PWR-1:0]         filtered_input;
	logic [N_PWR-1:0]         cmd_prev_r;
	logic [N_PWR-1:0]         cmd;
	logic [N_PWR-1:0]         skip_enable;
	logic [N_PWR-1:0]         input_sel_low;
	logic [N_PWR-1:0]         input_sel_high;
	logic [N_PWR-1:0]         global_duty_select;
	logic [DUTY_W-1:0]        global_duty_r;
	logic                     fail_mode;
	logic                     low_range;
	logic                     wr_en;
	logic [31:0]              rd_data;

	// a write lands at the edge where the master samples ack high
	assign wr_en = cyc_i && stb_i && we_i && ack_o;
	assign fail_mode = mode_r[MODE_FAIL];
	assign low_range = presc_r[PRESC_LOW];

	// ack one cycle after request, dropped the next cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= cyc_i && stb_i && !ack_o;
		end
	end

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// control register writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_ctrl_r <= REG_RESET;
			in_en_r <= REG_RESET;
			mode_r <= REG_RESET;
			presc_r <= REG_RESET;
			global_duty_r <= '0;
		end else if (wr_en) begin
			unique case (adr_i)
				ADDR_OUT_CTRL: out_ctrl_r <= merge(out_ctrl_r, dat_i, sel_i);
				ADDR_IN_EN: in_en_r <= merge(in_en_r, dat_i, sel_i);
				ADDR_MODE: mode_r <= merge(mode_r, dat_i, sel_i);
				ADDR_PRESC: presc_r <= merge(presc_r, dat_i, sel_i);
				ADDR_STATUS: if (sel_i[0]) global_duty_r <= dat_i[7:0];
				default: ;
			endcase
		end
	end

	// duty registers, one per channel, eight bits each
	genvar g;
	generate
		for (g = 0; g <= N_PWR; g++) begin : g_duty
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					duty_r[g] <= '0;
				end else if (wr_en && sel_i[0] &&
					adr_i == ADDR_DUTY0 + 8'(4*g)) begin
					duty_r[g] <= dat_i[DUTY_W-1:0];
				end
			end
		end
	endgenerate

	// register reads; unmapped reads return zero
	always_comb begin
		rd_data = '0;
		unique case (adr_i)
			ADDR_OUT_CTRL: rd_data = out_ctrl_r;
			ADDR_IN_EN: rd_data = in_en_r;
			ADDR_MODE: rd_data = mode_r;
			ADDR_PRESC: rd_data = presc_r;
			ADDR_STATUS: rd_data = {13'h0, frame_r, filtered_input,
				cmd, global_duty_r};
			default: begin
				for (int i = 0; i <= N_PWR; i++) begin
					if (adr_i == ADDR_DUTY0 + 8'(4*i)) begin
						rd_data = {24'h0, duty_r[i]};
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= '0;
		end else if (cyc_i && stb_i && !we_i && !ack_o) begin
			dat_o <= rd_data;
		end
	end

	// ************************************
	// input control
	// ************************************
	assign skip_enable = out_ctrl_r[OC_SKIP_LSB +: N_PWR];
	assign input_sel_low = in_en_r[0 +: N_PWR];
	assign input_sel_high = in_en_r[N_PWR +: N_PWR];
	assign global_duty_select = in_en_r[2*N_PWR +: N_PWR];

	logic [DUTY_W-1:0] req_duty [N_PWR];
	logic [DUTY_W-1:0] applied_r [N_PWR];
	logic [N_PWR-1:0]  use_global;

	generate
		for (g = 0; g < N_PWR; g++) begin : g_ch
			logic [1:0] sel;
			logic       on_bit;
			logic [DUTY_W-1:0] clamped;
			logic [2:0] rank;
			logic [DUTY_W-1:0] skipped;
			logic       skip_on;

			deglitch u_degl (
				.clk_i  (clk_i),
				.rst_i  (rst_i),
				.raw_i  (control_inputs_i[g]),
				.filt_o (filtered_input[g])
			);

			assign sel = {input_sel_high[g], input_sel_low[g]};
			assign on_bit = out_ctrl_r[OC_ON_LSB + g];
			// skip bit only counts in normal mode, else the top clamp returns
			assign skip_on = skip_enable[g] && !fail_mode;

			// channel command selection per mode and input enable
			always_comb begin
				if (fail_mode) begin
					cmd[g] = filtered_input[g];
				end else if (!on_bit) begin
					cmd[g] = 1'b0;
				end else if (sel == SEL_FORCE || sel == SEL_SWAP) begin
					cmd[g] = 1'b1;
				end else begin
					cmd[g] = filtered_input[g];
				end
			end

			// swap mode inverts duty source with the input level
			assign use_global[g] = (sel == SEL_SWAP) ?
				(global_duty_select[g] ^ filtered_input[g]) :
				global_duty_select[g];
			assign req_duty[g] = use_global[g] ? global_duty_r : duty_r[g];

			// clamp to usable range of the prescaler; FF stays full on
			always_comb begin
				clamped = req_duty[g];
				if (req_duty[g] != CODE_FULL) begin
					if (low_range) begin
						if (clamped < DUTY_MIN_LOW) clamped = DUTY_MIN_LOW;
						if (clamped > DUTY_MAX_LOW) clamped = DUTY_MAX_LOW;
					end else if (!skip_on) begin
						if (clamped < DUTY_MIN_MID) clamped = DUTY_MIN_MID;
						if (clamped > DUTY_MAX_MID) clamped = DUTY_MAX_MID;
					end else if (clamped < DUTY_MIN_MID) begin
						clamped = DUTY_MIN_MID;
					end
				end
			end

			// rank of the frame state in insertion order: bit-reversed index
			assign rank = {frame_r[0], frame_r[1], frame_r[2]};
			always_comb begin
				skipped = clamped;
				if (clamped > CODE_SKIP_LO && clamped != CODE_FULL) begin
					// code FF-k: F7 when rank < k, else FF
					skipped = (3'(CODE_FULL - clamped) > rank) ?
						CODE_SKIP_LO : CODE_FULL;
				end
			end

			// new duty taken only at period boundaries (full on at once)
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					applied_r[g] <= '0;
				end else if (period_start_i ||
					(req_duty[g] == CODE_FULL && cmd[g])) begin
					if (skip_on) begin
						applied_r[g] <= skipped;
					end else begin
						applied_r[g] <= clamped;
					end
				end
			end
			assign duty_value_o[g*DUTY_W +: DUTY_W] = applied_r[g];
		end
	endgenerate

	// frame index steps once per pwm period, wraps from last state to first
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frame_r <= '0;
		end else if (period_start_i) begin
			frame_r <= frame_r + 1'b1;
		end
	end

	// rising command edge starts the overcurrent window
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_prev_r <= '0;
		end else begin
			cmd_prev_r <= cmd;
		end
	end

	assign window_start_o = cmd & ~cmd_prev_r;
	assign window_ctrl_o = fail_mode ? filtered_input_alt_i : cmd;
	assign channel_command_o = cmd;
	assign wake_o = filtered_input;
	// channel six: on bit only, off in fail mode, never skipped
	assign channel_six_command_o = out_ctrl_r[OC_ON6] && !fail_mode;

	// ************************************
	// channel six duty
	// ************************************
	logic [DUTY_W-1:0] ext_lim;
	logic [DUTY_W-1:0] ext_applied_r;

	// same usable range as the power channels; there is no skip stage
	// here, so codes above the range top other than FF are simply held at the top
	always_comb begin
		ext_lim = duty_r[N_PWR];
		if (duty_r[N_PWR] != CODE_FULL) begin
			if (low_range) begin
				if (ext_lim < DUTY_MIN_LOW) ext_lim = DUTY_MIN_LOW;
				if (ext_lim > DUTY_MAX_LOW) ext_lim = DUTY_MAX_LOW;
			end else begin
				if (ext_lim < DUTY_MIN_MID) ext_lim = DUTY_MIN_MID;
				if (ext_lim > DUTY_MAX_MID) ext_lim = DUTY_MAX_MID;
			end
		end
	end

	// period aligned like the power channels, full on at once
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_applied_r <= '0;
		end else if (period_start_i ||
			(duty_r[N_PWR] == CODE_FULL && channel_six_command_o)) begin
			ext_applied_r <= ext_lim;
		end
	end
	assign ext_duty_value_o = ext_applied_r;
	assign pwm_enable_o = !fail_mode && !clk_fail_i;
endmodule

// File: core/skip_ctrl_pkg.sv
// constants, register map and types for the pulse skip and input control block
package skip_ctrl_pkg;
	localparam int N_PWR = 4;
	localparam int DUTY_W = 8;
	localparam int FRAME_W = 3;
	localparam int DEGL_W = 4;
	// deglitch filter: input must be stable this many clocks plus one
	localparam logic [DEGL_W-1:0] DEGL_COUNT = 4'hf;
	localparam logic [7:0] CODE_FULL = 8'hff;
	localparam logic [7:0] CODE_SKIP_LO = 8'hf7;
	// usable range per prescaler range; code n stands for n+1 lsb
	localparam logic [7:0] DUTY_MIN_LOW = 8'h03;
	localparam logic [7:0] DUTY_MAX_LOW = 8'hfb;
	localparam logic [7:0] DUTY_MIN_MID = 8'h07;
	localparam logic [7:0] DUTY_MAX_MID = 8'hf7;
	// frame states that take F7 for each extra skip: 0,4,2,6,1,5,3
	// order of F7 insertion for codes FE down to F8
	localparam logic [7:0] FRAME_RANK = {8'h7f};
	// register byte addresses (word aligned)
	localparam logic [7:0] ADDR_OUT_CTRL = 8'h00;
	localparam logic [7:0] ADDR_IN_EN = 8'h04;
	localparam logic [7:0] ADDR_MODE = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_DUTY0 = 8'h10;
	localparam logic [7:0] ADDR_DUTY6 = 8'h20;
	localparam logic [7:0] ADDR_PRESC = 8'h24;
	// field positions
	localparam int OC_ON_LSB = 0;
	localparam int OC_ON6 = 4;
	localparam int OC_SKIP_LSB = 8;
	localparam int MODE_FAIL = 0;
	localparam int PRESC_LOW = 0;
	localparam logic [31:0] REG_RESET = 32'h0;
	localparam logic [1:0] SEL_FORCE = 2'h0;
	localparam logic [1:0] SEL_SWAP = 2'h3;
endpackage

// File: sim/pulse_skip_and_input_control_test.sv
// self-checking bench for the pulse skip and input control block
module pulse_skip_and_input_control_test import skip_ctrl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, cf = 0;
	logic [7:0]  adr = 8'h00, ext;
	logic [3:0]  lvl = 4'h0, glt = 4'h0, alt = 4'h0;
	logic [3:0]  ctl, wake, cmd, wst, wct;
	logic [31:0] dat = 32'h0, q, dat_o, duty;
	logic        ack_o, ps, six, pen;
	int          miscompares = 0, check_count = 0, cycles = 0, wins = 0;
	skip_ctrl u_skip_ctrl (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat),
		.dat_o(dat_o), .ack_o(ack_o), .control_inputs_i(ctl),
		.filtered_input_alt_i(alt), .period_start_i(ps), .clk_fail_i(cf),
		.wake_o(wake), .channel_command_o(cmd), .channel_six_command_o(six),
		.window_start_o(wst), .window_ctrl_o(wct), .duty_value_o(duty),
		.ext_duty_value_o(ext), .pwm_enable_o(pen));
	pwm_host_model u_pwm_host_model (.clk_i(clk_i), .rst_i(rst_i),
		.level_i(lvl), .glitch_i(glt), .period_start_o(ps),
		.control_inputs_o(ctl));
	// ************
	// helpers
	// ************
	initial forever #25 clk_i = ~clk_i;
	// hang guard, also counts window pulses on channel 1
	always @(posedge clk_i) begin
		cycles++;
		if (wst[0] === 1'b1) wins++;
		if (cycles == 6000) begin
			miscompares++;
			report_and_stop;
		end
	end
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, e);
		check_count++;
		if (s !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	// one classic cycle; ack is looked at only on rising edges
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		cyc <= 0;
		stb <= 0;
	endtask
	task automatic per(input int n);
		repeat (n) begin
			do @(posedge clk_i); while (ps !== 1'b1);
			@(negedge clk_i);
		end
	endtask
	// ************
	// scenarios
	// ************
	task automatic t_regs;
		wb(0, ADDR_OUT_CTRL, 0);
		chk("out_ctrl", q, REG_RESET);
		wb(1, 8'h30, 32'hffffffff);
		wb(0, 8'h30, 0);
		chk("unmapped", q, 32'h0);
		wb(1, ADDR_DUTY6, 32'h5a);
		wb(0, ADDR_DUTY6, 0);
		chk("duty6_rd", q, 32'h5a);
	endtask
	task automatic t_skip;
		int n;
		logic [2:0] f;
		logic [7:0] e;
		// place of each frame state in the F7 insertion order
		int pos [8] = '{0, 4, 2, 6, 1, 5, 3, 7};
		wb(1, ADDR_OUT_CTRL, 32'h101);
		for (int k = 1; k < 8; k++) begin
			wb(1, ADDR_DUTY0, {24'h0, 8'hff - 8'(k)});
			per(2);
			// frame index read well clear of the next period start
			wb(0, ADDR_STATUS, 0);
			f = q[18:16];
			n = 0;
			for (int i = 0; i < 8; i++) begin
				per(1);
				if (duty[7:0] === CODE_SKIP_LO) n++;
				else chk("skip_ff", duty[7:0], CODE_FULL);
				e = (pos[3'(f + i)] < k) ? CODE_SKIP_LO : CODE_FULL;
				chk("skip_state", duty[7:0], e);
			end
			chk("skip_count", n, k);
		end
	endtask
	task automatic t_clamp;
		wb(1, ADDR_OUT_CTRL, 32'h11);
		wb(1, ADDR_DUTY0, 32'hfd);
		wb(1, ADDR_DUTY6, 32'hfd);
		for (int i = 0; i < 8; i++) begin
			per(1);
			chk("ext", ext, DUTY_MAX_MID);
			chk("plain", duty[7:0], DUTY_MAX_MID);
			chk("others", duty[31:8], {3{DUTY_MIN_MID}});
		end
		wb(1, ADDR_PRESC, 32'h1);
		per(2);
		chk("clamp_low", duty[7:0], DUTY_MAX_LOW);
		wb(1, ADDR_OUT_CTRL, 32'h101);
		wb(1, ADDR_PRESC, 32'h0);
		wb(1, ADDR_DUTY0, 32'h02);
		per(2);
		chk("low_end", duty[7:0], DUTY_MIN_MID);
	endtask
	task automatic t_input;
		wb(1, ADDR_IN_EN, 32'h1);
		lvl <= 4'h1;
		glt <= 4'h1;
		repeat (40) @(negedge clk_i);
		chk("glitch", {wake[0], cmd[0]}, 2'b00);
		wins = 0;
		@(posedge clk_i);
		glt <= 4'h0;
		repeat (24) @(negedge clk_i);
		chk("follow", {wake[0], cmd[0], six}, 3'b110);
		chk("window", wins, 1);
		@(posedge clk_i);
		lvl <= 4'h0;
		wb(1, ADDR_IN_EN, 32'h0);
		repeat (24) @(negedge clk_i);
		chk("forced", {wake[0], cmd[0]}, 2'b01);
		wb(1, ADDR_OUT_CTRL, 32'h10);
		@(negedge clk_i);
		chk("off", {cmd[0], six}, 2'b01);
	endtask
	task automatic t_fail;
		wb(1, ADDR_OUT_CTRL, 32'h111);
		lvl <= 4'h3;
		wb(1, ADDR_MODE, 32'h1);
		alt <= 4'h5;
		repeat (24) @(negedge clk_i);
		// power channels follow the filtered pins, windows the alt pins
		chk("fail", {pen, six, wake, cmd, wct}, {2'b00, 12'h335});
		wb(1, ADDR_DUTY0, 32'hfe);
		repeat (8) begin
			per(1);
			chk("fail_noskip", duty[7:0], DUTY_MAX_MID);
		end
		wb(1, ADDR_MODE, 32'h0);
		cf <= 1;
		repeat (3) @(negedge clk_i);
		chk("clk_fail", pen, 1'b0);
		@(posedge clk_i);
		cf <= 0;
		repeat (3) @(negedge clk_i);
		chk("clk_ok", pen, 1'b1);
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 0;
		t_regs;
		t_skip;
		t_clamp;
		t_input;
		t_fail;
		report_and_stop;
	end
endmodule

// File: sim/pwm_host_model.sv
// host side model: pwm period ticks and control input pins
module pwm_host_model #(
	parameter int PER = 8
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [3:0] level_i,
	input  wire logic [3:0] glitch_i,
	output logic            period_start_o,
	output logic [3:0]      control_inputs_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt_r;
	// period counter, one tick every PER clocks
	always_ff @(posedge clk_i) begin
		if (rst_i || cnt_r == 8'(PER - 1))
			cnt_r <= 8'h00;
		else
			cnt_r <= cnt_r + 8'h01;
	end
	assign period_start_o = (cnt_r == 8'h00) && !rst_i;
	// glitching pins flip every two clocks, far under the filter time
	always_ff @(posedge clk_i) begin
		control_inputs_o <= level_i ^ (glitch_i & {4{cnt_r[1]}});
	end
endmodule

// File: sim/skip_ctrl_monitor.sv
// concurrent checks on the pulse skip block ports
module skip_ctrl_monitor (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        ack_o,
	input wire logic [3:0]  control_inputs_i,
	input wire logic [3:0]  wake_o,
	input wire logic [3:0]  channel_command_o,
	input wire logic [3:0]  window_start_o,
	input wire logic        period_start_i,
	input wire logic        clk_fail_i,
	input wire logic        pwm_enable_o,
	input wire logic [31:0] duty_value_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ************
	// bus, filter, window, clock fail, duty timing
	// ************
	sequence s_req; cyc_i && stb_i && !ack_o; endsequence
	sequence s_filt; $changed(wake_o[0]); endsequence
	property p_ack; s_req |=> ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack missing");
	property p_ack_one; ack_o |=> !ack_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack too long");
	// filter needs the pin stable well before it moves
	property p_degl; s_filt |-> $past(control_inputs_i[0], 4) == wake_o[0]
		&& $past(control_inputs_i[0], 12) == wake_o[0]; endproperty
	a_degl: assert property (p_degl) else $error("glitch passed");
	property p_win; $rose(channel_command_o[0]) |-> ##[0:1] window_start_o[0];
	endproperty
	a_win: assert property (p_win) else $error("no window start");
	property p_win_one; window_start_o[0] |=> !window_start_o[0]; endproperty
	a_win_one: assert property (p_win_one) else $error("window long");
	property p_cf; clk_fail_i [*2] |-> !pwm_enable_o; endproperty
	a_cf: assert property (p_cf) else $error("pwm on in clock fail");
	// zero and full scale may move at once, others wait for a period
	property p_sync; $changed(duty_value_o[7:0]) && duty_value_o[7:0] != 8'hff
		&& duty_value_o[7:0] != 8'h00 |-> $past(period_start_i); endproperty
	a_sync: assert property (p_sync) else $error("duty moved mid period");
	property p_min; !(duty_value_o[7:0] inside {8'h01, 8'h02});
	endproperty
	a_min: assert property (p_min) else $error("duty below floor");
endmodule
bind skip_ctrl skip_ctrl_monitor u_skip_ctrl_monitor (.clk_i(clk_i),
	.rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
	.control_inputs_i(control_inputs_i), .wake_o(wake_o),
	.channel_command_o(channel_command_o), .window_start_o(window_start_o),
	.period_start_i(period_start_i), .clk_fail_i(clk_fail_i),
	.pwm_enable_o(pwm_enable_o), .duty_value_o(duty_value_o));
